// file: rtl/supervision_map.svh
// Register offsets, field positions, reset values and timing counts
// for the supervision timer. Definitions only; included by the package.
`ifndef SUPERVISION_MAP_SVH
`define SUPERVISION_MAP_SVH

// Register offsets: data space, and the reduced short-instruction space
`define CAUSE_DS_OFS 8'h54
`define CAUSE_IO_OFS 8'h34
`define CTRL_DS_OFS 8'h60

// Reset values
`define CAUSE_RST 8'h00
`define CTRL_RST 8'h00

// Control register field positions
`define CTRL_FLAG_BIT 7
`define CTRL_IE_BIT 6
`define CTRL_PMSB_BIT 5
`define CTRL_CE_BIT 4
`define CTRL_RE_BIT 3

// Reset cause register field positions
`define CAUSE_SCAN_BIT 4
`define CAUSE_SUP_BIT 3
`define CAUSE_BO_BIT 2
`define CAUSE_PIN_BIT 1
`define CAUSE_PWR_BIT 0

// Timing: change window in system clocks, periods in oscillator cycles
`define CE_WINDOW_CYC 3'h4
`define OSC_FREQ_HZ 128000
`define SHORTEST_TIMEOUT_MS 16
`define BASE_PERIOD_OSC (`OSC_FREQ_HZ * `SHORTEST_TIMEOUT_MS / 1000)
`define MAX_PERIOD_CODE 4'h9
`define CNT_W 20

`endif

// file: rtl/supervision_pkg.sv
// Types shared by the supervision timer and its oscillator tick counter.
// Assumes supervision_map.svh is on the include path.
`include "supervision_map.svh"

package supervision_pkg;

   // One register access from the CPU, taken in the cycle it is presented
   typedef struct packed {
      logic wr;
      logic rd;
      logic io_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic flag;
      logic ie;
      logic [3:0] psel;
      logic ce;
      logic re;
   } ctrl_t;

   typedef struct packed {
      logic scan;
      logic sup;
      logic bo;
      logic pin;
      logic pwr;
   } cause_t;

   typedef enum logic [1:0] {
      MODE_STOPPED,
      MODE_IRQ,
      MODE_RESET,
      MODE_IRQ_RESET
   } op_mode_t;

   typedef struct packed {
      ctrl_t ctrl;
      cause_t cause;
      logic [2:0] ce_cnt;
      logic [7:0] rdata;
      logic irq;
      logic wake;
      logic sys_rst;
   } core_state_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic osc_d;
      logic [`CNT_W-1:0] count;
      logic expire;
   } tick_state_t;

endpackage

// file: rtl/osc_tick_counter.sv
// Counts rising edges of the slow oscillator in the system clock domain.
// Assumes osc_clk is far slower than clock and asynchronous to it.
`timescale 1ns/1ns
`include "supervision_map.svh"

module osc_tick_counter (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Oscillator, asynchronous
   input wire logic osc_clk,
   // Control from the timer core
   input wire logic restart,
   input wire logic [`CNT_W-1:0] limit,
   // Results
   output logic expire,
   output logic [`CNT_W-1:0] count
);

   supervision_pkg::tick_state_t s_r;
   supervision_pkg::tick_state_t s_nxt;

   // Two-stage sync, then edge detect on the second stage only
   always_comb begin
      s_nxt = s_r;
      s_nxt.sync1 = osc_clk;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.osc_d = s_r.sync2;
      s_nxt.expire = 1'b0;
      if (rst) begin
         // Sync stages keep running, so no false edge follows reset
         s_nxt.count = '0;
      end else if (restart) begin
         s_nxt.count = '0;
      end else if (s_r.sync2 && !s_r.osc_d) begin
         // >= so a shortened period expires at the next oscillator edge
         if (s_r.count >= limit) begin
            s_nxt.count = '0;
            s_nxt.expire = 1'b1;
         end else begin
            s_nxt.count = s_r.count + `CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clock) begin
      s_r <= s_nxt;
   end

   assign expire = s_r.expire;
   assign count = s_r.count;

endmodule

// file: rtl/supervision_timer.sv
// Supervision timer with control/status and reset cause registers.
// Assumes a CPU register port on the same clock, a reset generator that
// reports each reset cause as a same-clock pulse, and a free slow oscillator.
`timescale 1ns/1ns
`include "supervision_map.svh"

module supervision_timer (
   // Clock and resets
   input wire logic clock,
   input wire logic rst,
   input wire logic por,
   // Reset cause events from the reset generator
   input wire logic pin_reset_evt,
   input wire logic brownout_evt,
   input wire logic scan_reset_evt,
   // Slow oscillator
   input wire logic osc_clk,
   // CPU register port
   input wire supervision_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // CPU core signals
   input wire logic restart_instr,
   input wire logic global_ie,
   input wire logic vector_ack,
   // Fuse
   input wire logic always_on_fuse,
   // Requests
   output logic irq_req,
   output logic wake_req,
   output logic sys_reset_req
);

   supervision_pkg::core_state_t s_r;
   supervision_pkg::core_state_t s_nxt;
   supervision_pkg::op_mode_t mode;
   logic re_eff;
   logic ie_eff;
   logic cause_hit;
   logic ctrl_hit;
   logic cause_wr;
   logic ctrl_wr;
   logic unlock_wr;
   logic win_open;
   logic [7:0] cause_rd;
   logic [7:0] ctrl_rd;
   logic expire;
   logic cnt_restart;
   logic [`CNT_W-1:0] limit;
   logic [`CNT_W-1:0] tick_count;

   // Period code to terminal count; reserved codes act as the longest
   function automatic logic [`CNT_W-1:0] period_limit(input logic [3:0] code);
      logic [3:0] c;
      logic [31:0] cyc;
      c = (code > `MAX_PERIOD_CODE) ? `MAX_PERIOD_CODE : code;
      cyc = (32'(`BASE_PERIOD_OSC) << c) - 32'h1;
      return cyc[`CNT_W-1:0];
   endfunction

   // Mode from the effective enables
   function automatic supervision_pkg::op_mode_t mode_of(input logic re, input logic ie);
      if (re && ie) begin
         return supervision_pkg::MODE_IRQ_RESET;
      end else if (re) begin
         return supervision_pkg::MODE_RESET;
      end else if (ie) begin
         return supervision_pkg::MODE_IRQ;
      end else begin
         return supervision_pkg::MODE_STOPPED;
      end
   endfunction

   // Effective enables; fuse and reset flag override what is stored
   assign re_eff = always_on_fuse | s_r.ctrl.re | s_r.cause.sup;
   assign ie_eff = s_r.ctrl.ie & ~always_on_fuse;
   assign mode = mode_of(re_eff, ie_eff);

   // Address decode for both access spaces
   always_comb begin
      cause_hit = 1'b0;
      ctrl_hit = 1'b0;
      if (reg_req.io_space && reg_req.addr == `CAUSE_IO_OFS) begin
         cause_hit = 1'b1;
      end else if (!reg_req.io_space && reg_req.addr == `CAUSE_DS_OFS) begin
         cause_hit = 1'b1;
      end else if (!reg_req.io_space && reg_req.addr == `CTRL_DS_OFS) begin
         ctrl_hit = 1'b1;
      end
   end

   assign cause_wr = cause_hit & reg_req.wr;
   assign ctrl_wr = ctrl_hit & reg_req.wr;
   assign win_open = s_r.ce_cnt != 3'h0;
   assign unlock_wr = ctrl_wr & reg_req.wdata[`CTRL_CE_BIT]
                      & reg_req.wdata[`CTRL_RE_BIT];

   // Read images; upper cause bits read as zero
   always_comb begin
      cause_rd = 8'h00;
      cause_rd[`CAUSE_SCAN_BIT] = s_r.cause.scan;
      cause_rd[`CAUSE_SUP_BIT] = s_r.cause.sup;
      cause_rd[`CAUSE_BO_BIT] = s_r.cause.bo;
      cause_rd[`CAUSE_PIN_BIT] = s_r.cause.pin;
      cause_rd[`CAUSE_PWR_BIT] = s_r.cause.pwr;
      ctrl_rd = 8'h00;
      ctrl_rd[`CTRL_FLAG_BIT] = s_r.ctrl.flag;
      ctrl_rd[`CTRL_IE_BIT] = ie_eff;
      ctrl_rd[`CTRL_PMSB_BIT] = s_r.ctrl.psel[3];
      ctrl_rd[`CTRL_CE_BIT] = s_r.ctrl.ce;
      ctrl_rd[`CTRL_RE_BIT] = re_eff;
      ctrl_rd[2:0] = s_r.ctrl.psel[2:0];
   end

   // Main next-state logic: window, writes, vector, expiry, causes
   always_comb begin
      s_nxt = s_r;
      s_nxt.sys_rst = 1'b0;
      // Change window countdown
      if (win_open) begin
         s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
         if (s_r.ce_cnt == 3'h1) begin
            s_nxt.ctrl.ce = 1'b0;
         end
      end
      // Reads return the image one cycle later; unmapped reads give zero
      if (reg_req.rd) begin
         if (cause_hit) begin
            s_nxt.rdata = cause_rd;
         end else if (ctrl_hit) begin
            s_nxt.rdata = ctrl_rd;
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end
      // Control writes
      if (ctrl_wr) begin
         if (reg_req.wdata[`CTRL_FLAG_BIT]) begin
            s_nxt.ctrl.flag = 1'b0;
         end
         s_nxt.ctrl.ie = reg_req.wdata[`CTRL_IE_BIT];
         if (unlock_wr) begin
            s_nxt.ce_cnt = `CE_WINDOW_CYC;
            s_nxt.ctrl.ce = 1'b1;
            s_nxt.ctrl.re = 1'b1;
         end else if (win_open) begin
            // One settings write consumes the window
            s_nxt.ctrl.re = reg_req.wdata[`CTRL_RE_BIT] | s_r.cause.sup;
            s_nxt.ctrl.psel = {reg_req.wdata[`CTRL_PMSB_BIT], reg_req.wdata[2:0]};
            s_nxt.ctrl.ce = 1'b0;
            s_nxt.ce_cnt = 3'h0;
         end else begin
            // Outside the window reset enable may only be set
            s_nxt.ctrl.re = s_r.ctrl.re | reg_req.wdata[`CTRL_RE_BIT];
         end
      end
      // Vector execution clears enable and flag
      if (vector_ack) begin
         s_nxt.ctrl.flag = 1'b0;
         s_nxt.ctrl.ie = 1'b0;
      end
      // Expiry after the clears, so a new event wins over them
      if (expire) begin
         case (mode)
            supervision_pkg::MODE_IRQ: begin
               s_nxt.ctrl.flag = 1'b1;
            end
            supervision_pkg::MODE_RESET: begin
               s_nxt.sys_rst = 1'b1;
            end
            supervision_pkg::MODE_IRQ_RESET: begin
               // A flag still pending means the interrupt was not served
               if (s_r.ctrl.flag) begin
                  s_nxt.sys_rst = 1'b1;
               end else begin
                  s_nxt.ctrl.flag = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // Cause flags: write zero clears, events set and win
      if (cause_wr) begin
         s_nxt.cause.scan = s_r.cause.scan & reg_req.wdata[`CAUSE_SCAN_BIT];
         s_nxt.cause.sup = s_r.cause.sup & reg_req.wdata[`CAUSE_SUP_BIT];
         s_nxt.cause.bo = s_r.cause.bo & reg_req.wdata[`CAUSE_BO_BIT];
         s_nxt.cause.pin = s_r.cause.pin & reg_req.wdata[`CAUSE_PIN_BIT];
         s_nxt.cause.pwr = s_r.cause.pwr & reg_req.wdata[`CAUSE_PWR_BIT];
      end
      if (scan_reset_evt) begin
         s_nxt.cause.scan = 1'b1;
      end
      if (s_nxt.sys_rst) begin
         s_nxt.cause.sup = 1'b1;
      end
      if (brownout_evt) begin
         s_nxt.cause.bo = 1'b1;
      end
      if (pin_reset_evt) begin
         s_nxt.cause.pin = 1'b1;
      end
      // Registered request outputs
      s_nxt.irq = s_nxt.ctrl.flag & s_nxt.ctrl.ie & ~always_on_fuse & global_ie;
      s_nxt.wake = s_nxt.ctrl.flag & s_nxt.ctrl.ie & ~always_on_fuse;
      // System reset keeps the cause flags; they must survive it
      if (rst) begin
         s_nxt.ctrl = supervision_pkg::ctrl_t'(`CTRL_RST);
         s_nxt.ce_cnt = 3'h0;
         s_nxt.rdata = 8'h00;
         s_nxt.irq = 1'b0;
         s_nxt.wake = 1'b0;
         s_nxt.sys_rst = 1'b0;
      end
      // Power-on clears everything and leaves only the power-up flag
      if (por) begin
         s_nxt = '0;
         s_nxt.cause = supervision_pkg::cause_t'(5'(`CAUSE_RST));
         s_nxt.cause.pwr = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      s_r <= s_nxt;
   end

   // Counter held at zero while stopped, so enabling starts a full period
   assign cnt_restart = restart_instr | rst | por
                        | (mode == supervision_pkg::MODE_STOPPED);
   assign limit = period_limit(s_r.ctrl.psel);

   osc_tick_counter u_ticks (
      .clock(clock),
      .rst(rst | por),
      .osc_clk(osc_clk),
      .restart(cnt_restart),
      .limit(limit),
      .expire(expire),
      .count(tick_count)
   );

   assign reg_rdata = s_r.rdata;
   assign irq_req = s_r.irq;
   assign wake_req = s_r.wake;
   assign sys_reset_req = s_r.sys_rst;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst || por);

   // Change window and protected fields
   chk_ce_window: assert property (unlock_wr ##1 (!ctrl_wr)[*4] |=> !s_r.ctrl.ce)
      else $error("change enable not cleared after four cycles");
   chk_ce_held: assert property (unlock_wr ##1 (!ctrl_wr)[*3] |-> s_r.ctrl.ce)
      else $error("change enable dropped early");
   chk_psel_locked: assert property (
      ctrl_wr && !win_open && !unlock_wr |=> $stable(s_r.ctrl.psel))
      else $error("period changed outside the window");
   chk_ce_unlock: assert property (unlock_wr |=> s_r.ctrl.ce && s_r.ctrl.re)
      else $error("unlock did not open the window");
   chk_window_apply: assert property (
      ctrl_wr && win_open && !unlock_wr
      |=> !s_r.ctrl.ce && s_r.ctrl.psel[2:0] == $past(reg_req.wdata[2:0]))
      else $error("settings write in the window not applied");
   // Mode forcing and read-back; the fuse must also silence interrupts
   chk_fuse_mode: assert property (always_on_fuse |-> mode == supervision_pkg::MODE_RESET)
      else $error("fuse did not force reset mode");
   chk_fuse_no_irq: assert property (always_on_fuse |=> !wake_req && !irq_req)
      else $error("interrupt request with the fuse programmed");
   chk_sup_forces: assert property (
      s_r.cause.sup && ctrl_hit && reg_req.rd |=> reg_rdata[`CTRL_RE_BIT])
      else $error("reset enable reads zero with reset flag set");
   chk_unmapped_read: assert property (
      reg_req.rd && !cause_hit && !ctrl_hit |=> reg_rdata == 8'h00)
      else $error("unmapped read returned data");
   // Expiry outcomes per mode
   chk_reset_mode: assert property (
      expire && mode == supervision_pkg::MODE_RESET |=> sys_reset_req && s_r.cause.sup)
      else $error("no reset on expiry in reset mode");
   chk_rst_pulse: assert property (sys_reset_req |=> !sys_reset_req)
      else $error("system reset request longer than one cycle");
   chk_irq_mode: assert property (
      expire && mode == supervision_pkg::MODE_IRQ |=> s_r.ctrl.flag && !sys_reset_req)
      else $error("interrupt mode expiry misbehaved");
   chk_combined_first: assert property (
      expire && mode == supervision_pkg::MODE_IRQ_RESET && !s_r.ctrl.flag
      |=> s_r.ctrl.flag && !sys_reset_req)
      else $error("combined mode first expiry wrong");
   chk_stopped_hold: assert property (
      mode == supervision_pkg::MODE_STOPPED |=> tick_count == '0 && !expire)
      else $error("counter ran while stopped");
   chk_vector_clears: assert property (
      vector_ack && !expire && !ctrl_wr |=> !s_r.ctrl.flag && !s_r.ctrl.ie)
      else $error("vector did not clear enable and flag");
   // Request outputs, counter and cause flags
   chk_irq_gate: assert property (irq_req |-> $past(global_ie) && s_r.ctrl.flag)
      else $error("interrupt raised without enables");
   chk_wake_level: assert property (
      wake_req == (s_r.ctrl.flag && s_r.ctrl.ie && !$past(always_on_fuse)))
      else $error("wake request does not follow flag and enable");
   chk_restart_count: assert property (restart_instr |=> tick_count == '0)
      else $error("restart did not clear the counter");
   chk_pin_clear: assert property (
      cause_wr && !reg_req.wdata[`CAUSE_PIN_BIT] && !pin_reset_evt |=> !s_r.cause.pin)
      else $error("pin reset flag not cleared by zero write");
   chk_sup_set: assert property (sys_reset_req |-> s_r.cause.sup)
      else $error("reset flag not set with the reset request");
   chk_por_flags: assert property (@(posedge clock) disable iff (1'b0)
      por |=> s_r.cause == 5'h01)
      else $error("power-on did not leave only the power-up flag");

   // Main scenarios
   cov_unlock_change: cover property (unlock_wr ##[1:4] (ctrl_wr && win_open));
   cov_combined_reset: cover property (expire && mode == supervision_pkg::MODE_IRQ_RESET
      && s_r.ctrl.flag);
   cov_irq_taken: cover property (irq_req ##[1:8] vector_ack);
   cov_irq_wake: cover property (expire && mode == supervision_pkg::MODE_IRQ);

endmodule

// file: test/tb.sv
// Self-checking bench for the supervision timer: register access, unlock window,
// interrupt, combined and reset modes, cause flags and the always-on fuse.
// Assumes rtl/ on the include path; the bench stands in for CPU and reset generator.
`timescale 1ns/1ns

module tb;
   // Clock, resets and stimulus
   logic clock;
   logic rst;
   logic por;
   logic pin_reset_evt;
   logic brownout_evt;
   logic scan_reset_evt;
   logic osc_clk;
   supervision_pkg::reg_req_t reg_req;
   logic restart_instr;
   logic global_ie;
   logic vector_ack;
   logic always_on_fuse;
   // Observed outputs
   logic [7:0] reg_rdata;
   logic irq_req;
   logic wake_req;
   logic sys_reset_req;
   int failures;
   int cmp_count;
   int n;

   supervision_timer DUT (
      .clock(clock), .rst(rst), .por(por),
      .pin_reset_evt(pin_reset_evt), .brownout_evt(brownout_evt),
      .scan_reset_evt(scan_reset_evt), .osc_clk(osc_clk),
      .reg_req(reg_req), .reg_rdata(reg_rdata),
      .restart_instr(restart_instr), .global_ie(global_ie), .vector_ack(vector_ack),
      .always_on_fuse(always_on_fuse),
      .irq_req(irq_req), .wake_req(wake_req), .sys_reset_req(sys_reset_req)
   );

   // System clock, 100 MHz
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Slow oscillator sped up to 8 clocks a cycle, off phase with the clock
   initial begin
      osc_clk = 1'b0;
      #3;
      forever #40 osc_clk = ~osc_clk;
   end

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // All driving happens 1 ns after a rising edge
   task automatic step();
      @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
      step();
      reg_req = '{wr: 1'b1, rd: 1'b0, io_space: io, addr: a, wdata: d};
      step();
      reg_req.wr = 1'b0;
   endtask

   // Read data is registered on the taking edge, so it is settled 1 ns later
   task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp);
      step();
      reg_req = '{wr: 1'b0, rd: 1'b1, io_space: io, addr: a, wdata: 8'h00};
      step();
      reg_req.rd = 1'b0;
      chk(reg_rdata, exp, "register read");
   endtask

   task automatic unlock_wr(input logic [7:0] d);
      wr(1'b0, 8'h60, 8'h18);
      wr(1'b0, 8'h60, d);
   endtask

   // Bounded wait on one output: 0 wake, 1 irq, 2 system reset
   task automatic wait_out(input int sel, output int cycles);
      logic v;
      cycles = 0;
      v = 1'b0;
      while (v !== 1'b1 && cycles < 20000) begin
         step();
         cycles++;
         v = (sel == 0) ? wake_req : (sel == 1) ? irq_req : sys_reset_req;
      end
      chk({7'h00, v}, 8'h01, "output never rose");
   endtask

   task automatic do_reset(input logic with_por);
      rst = 1'b1;
      por = with_por;
      repeat (2) step();
      rst = 1'b0;
      por = 1'b0;
   endtask

   // Hang guard, beyond the roughly 75k cycles of the sequence but under 100k
   initial begin
      #950000;
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      failures = 0;
      cmp_count = 0;
      rst = 1'b1;
      por = 1'b1;
      {pin_reset_evt, brownout_evt, scan_reset_evt} = 3'h0;
      reg_req = '0;
      {restart_instr, global_ie, vector_ack, always_on_fuse} = 4'h0;
      repeat (2) step();
      rst = 1'b0;
      por = 1'b0;
      // Reset images and both address spaces
      rd(1'b0, 8'h54, 8'h01);
      rd(1'b0, 8'h60, 8'h00);
      rd(1'b1, 8'h34, 8'h01);
      rd(1'b1, 8'h54, 8'h00);
      // Cause events set, ones ignored, zeros clear, power-on clears
      step();
      {pin_reset_evt, brownout_evt, scan_reset_evt} = 3'h7;
      step();
      {pin_reset_evt, brownout_evt, scan_reset_evt} = 3'h0;
      rd(1'b0, 8'h54, 8'h17);
      wr(1'b1, 8'h34, 8'hff);
      rd(1'b0, 8'h54, 8'h17);
      wr(1'b0, 8'h54, 8'h00);
      rd(1'b0, 8'h54, 8'h00);
      step();
      {pin_reset_evt, brownout_evt, scan_reset_evt} = 3'h7;
      step();
      {pin_reset_evt, brownout_evt, scan_reset_evt} = 3'h0;
      do_reset(1'b1);
      rd(1'b0, 8'h54, 8'h01);
      // Protected fields outside the window
      wr(1'b0, 8'h60, 8'h05);
      rd(1'b0, 8'h60, 8'h00);
      wr(1'b0, 8'h60, 8'h08);
      rd(1'b0, 8'h60, 8'h08);
      // Window opens on unlock and closes by itself
      wr(1'b0, 8'h60, 8'h18);
      rd(1'b0, 8'h60, 8'h18);
      repeat (4) step();
      rd(1'b0, 8'h60, 8'h08);
      restart_instr = 1'b1;
      step();
      restart_instr = 1'b0;
      unlock_wr(8'h2d);
      rd(1'b0, 8'h60, 8'h2d);
      unlock_wr(8'h00);
      rd(1'b0, 8'h60, 8'h00);
      // Interrupt mode at the shortest period, global enable off
      wr(1'b0, 8'h60, 8'h40);
      wait_out(0, n);
      chk({7'h00, n >= 16360 && n <= 16420}, 8'h01, "period length");
      chk({7'h00, irq_req}, 8'h00, "irq without global enable");
      rd(1'b0, 8'h60, 8'hc0);
      global_ie = 1'b1;
      step();
      step();
      chk({7'h00, irq_req}, 8'h01, "irq with global enable");
      chk({7'h00, sys_reset_req}, 8'h00, "reset in irq mode");
      wr(1'b0, 8'h60, 8'hc0);
      rd(1'b0, 8'h60, 8'h40);
      chk({7'h00, irq_req}, 8'h00, "irq after flag clear");
      // Combined mode: interrupt, vector, then reset
      wr(1'b0, 8'h60, 8'h48);
      step();
      restart_instr = 1'b1;
      step();
      restart_instr = 1'b0;
      wait_out(1, n);
      chk({7'h00, sys_reset_req}, 8'h00, "reset on first expiry");
      vector_ack = 1'b1;
      step();
      vector_ack = 1'b0;
      rd(1'b0, 8'h60, 8'h08);
      wait_out(2, n);
      step();
      chk({7'h00, sys_reset_req}, 8'h00, "reset pulse length");
      rd(1'b0, 8'h54, 8'h09);
      // The reset generator answers; the timer must stay enabled
      do_reset(1'b0);
      rd(1'b0, 8'h60, 8'h08);
      rd(1'b0, 8'h54, 8'h09);
      unlock_wr(8'h00);
      rd(1'b0, 8'h60, 8'h08);
      wr(1'b0, 8'h54, 8'h01);
      rd(1'b0, 8'h54, 8'h01);
      unlock_wr(8'h00);
      rd(1'b0, 8'h60, 8'h00);
      // Reset mode kept alive by restarts, then left to expire
      wr(1'b0, 8'h60, 8'h08);
      n = 0;
      repeat (10) begin
         repeat (800) begin
            step();
            if (sys_reset_req !== 1'b0) begin
               n++;
            end
         end
         restart_instr = 1'b1;
         step();
         restart_instr = 1'b0;
      end
      chk(n[7:0], 8'h00, "reset despite restarts");
      wait_out(2, n);
      chk({7'h00, n >= 16360 && n <= 16420}, 8'h01, "time from last restart");
      // Always-on fuse locks reset on and interrupt off
      do_reset(1'b1);
      always_on_fuse = 1'b1;
      rd(1'b0, 8'h60, 8'h08);
      wr(1'b0, 8'h60, 8'h40);
      rd(1'b0, 8'h60, 8'h08);
      always_on_fuse = 1'b0;
      wrap_up();
   end
endmodule
